// >>> hdl/aptc_defines.vh
// Register offsets, field positions, reset values and trigger codes of the pair trigger controller
`ifndef APTC_DEFINES_VH
`define APTC_DEFINES_VH
`define APTC_OFF_GLOBAL_CONTROL 4'h0
`define APTC_OFF_PAIR_CONTROL_0 4'h4
`define APTC_OFF_PAIR_CONTROL_3 4'h8
`define APTC_OFF_PAIR_STATUS 4'hC
`define APTC_BIT_CONV_ON 15
`define APTC_BIT_IDLE_STOP 13
`define APTC_BIT_CLOCK_SELECT 12
`define APTC_BIT_GLOBAL_TRIG 10
`define APTC_BIT_FORMAT 8
`define APTC_BIT_IRQ_ENABLE 7
`define APTC_BIT_PENDING 6
`define APTC_BIT_SOFT_TRIG 5
`define APTC_GLOBAL_RESET 16'h0003
`define APTC_GLOBAL_WMASK 16'hB5FF
`define APTC_LOCKED_MASK 16'h11EF
`define APTC_PAIR_RESET 8'h00
`define APTC_TS_NONE 5'h00
`define APTC_TS_INDIV_SW 5'h01
`define APTC_TS_GLOBAL_SW 5'h02
`define APTC_TS_PWM_SPECIAL 5'h03
`define APTC_TS_PWM1_PRI 5'h04
`define APTC_TS_PWM2_PRI 5'h05
`define APTC_TS_PWM4_PRI 5'h07
`define APTC_TS_TMR1 5'h0C
`define APTC_TS_PWM1_SEC 5'h0E
`define APTC_TS_PWM2_SEC 5'h0F
`define APTC_TS_PWM4_SEC 5'h11
`define APTC_TS_PWM1_CL 5'h17
`define APTC_TS_PWM2_CL 5'h18
`define APTC_TS_PWM4_CL 5'h1A
`define APTC_TS_TMR2 5'h1F
`define APTC_AXI_OKAY 2'h0
`define APTC_AXI_SLVERR 2'h2
`endif

// >>> hdl/aptc_pair_slot.v
// One channel pair: trigger select, pending flag and self-clearing software trigger
`timescale 1ns/1ns
`include "aptc_defines.vh"
module aptc_pair_slot (
  input wire i_clk, // System clock
  input wire i_resetn, // Async reset, active low
  input wire i_run, // Converter on and not idle-stopped
  input wire [4:0] i_sel, // Trigger source selector
  input wire i_soft_trig, // Individual software trigger bit
  input wire i_global_trig, // Global software trigger bit
  input wire [10:0] i_hw_trig, // Hardware trigger events
  input wire i_grant, // Converter takes this pair now
  input wire i_done, // Converter finished this pair
  output reg o_pending, // Conversion pending
  output reg o_busy, // Conversion in the converter
  output wire o_soft_clear // Pending set while soft trigger on, drop soft trigger
);
  reg trig_fire;
  reg gsw_q_reg;
  // Trigger mux; reserved codes and code zero select nothing
  always @* begin
    case (i_sel)
      `APTC_TS_INDIV_SW: trig_fire = i_soft_trig;
      `APTC_TS_GLOBAL_SW: trig_fire = i_global_trig & ~gsw_q_reg;
      `APTC_TS_PWM_SPECIAL: trig_fire = i_hw_trig[0];
      `APTC_TS_PWM1_PRI: trig_fire = i_hw_trig[1];
      `APTC_TS_PWM2_PRI: trig_fire = i_hw_trig[2];
      `APTC_TS_PWM4_PRI: trig_fire = i_hw_trig[3];
      `APTC_TS_PWM1_SEC: trig_fire = i_hw_trig[4];
      `APTC_TS_PWM2_SEC: trig_fire = i_hw_trig[5];
      `APTC_TS_PWM4_SEC: trig_fire = i_hw_trig[6];
      `APTC_TS_PWM1_CL: trig_fire = i_hw_trig[7];
      `APTC_TS_PWM2_CL: trig_fire = i_hw_trig[8];
      `APTC_TS_PWM4_CL: trig_fire = i_hw_trig[9];
      `APTC_TS_TMR1: trig_fire = i_hw_trig[10];
      `APTC_TS_TMR2: trig_fire = i_hw_trig[10];
      default: trig_fire = 1'b0;
    endcase
  end
  // Timer2 shares bit 10 with timer1 here; the top swaps in the timer2 pulse for that code
  assign o_soft_clear = o_pending & i_soft_trig;
  // Pending holds the request until this pair's conversion is done; done also wins over a trigger in the same cycle
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pending <= 1'b0;
      o_busy <= 1'b0;
      gsw_q_reg <= 1'b0;
    end else begin
      gsw_q_reg <= i_global_trig;
      if (i_run && trig_fire && !o_pending) begin
        o_pending <= 1'b1;
      end else if (i_done) begin
        o_pending <= 1'b0;
      end
      if (i_grant) begin
        o_busy <= 1'b1;
      end else if (i_done) begin
        o_busy <= 1'b0;
      end
    end
  end
endmodule

// >>> hdl/aptc_top.v
// Converter global control, pair trigger control and AXI4-Lite register slave
//
// Behaviour
// - Bit 15 turns converter on; resets off
// - Bit 13 halts converter while device idles
// - Bit 12 picks auxiliary or primary clock
// - Global trigger starts pairs selecting it
// - Every pair has independent trigger path
// - Pair byte: selector, irq, pending, trigger
// - Irq enable raises request on completion
// - Pending sets on trigger, clears when done
// - Soft trigger starts pair, auto clears
// - Busy converter holds request until free
// - Code 0 disables, code 1 individual
// - Code 00011 picks PWM special event
// - Codes pick PWM 1,2,4 primary
// - Codes pick PWM 1,2,4 secondary
// - Codes pick PWM 1,2,4 current limit
// - Codes pick timer1 and timer2 period
// - Last pair always flagged as internal reference
`timescale 1ns/1ns
`include "aptc_defines.vh"
module aptc_top #(
  parameter NPAIR = 3 // Pairs: 0, 1 and the reference pair
) (
  input wire i_clk, // System clock
  input wire i_resetn, // Async reset, active low
  input wire [3:0] i_awaddr, // Write address
  input wire i_awvalid, // Write address valid
  output reg o_awready, // Write address ready
  input wire [31:0] i_wdata, // Write data
  input wire [3:0] i_wstrb, // Write byte strobes
  input wire i_wvalid, // Write data valid
  output reg o_wready, // Write data ready
  output reg [1:0] o_bresp, // Write response
  output reg o_bvalid, // Write response valid
  input wire i_bready, // Write response ready
  input wire [3:0] i_araddr, // Read address
  input wire i_arvalid, // Read address valid
  output reg o_arready, // Read address ready
  output reg [31:0] o_rdata, // Read data
  output reg [1:0] o_rresp, // Read response
  output reg o_rvalid, // Read data valid
  input wire i_rready, // Read data ready
  input wire i_idle, // Device in idle mode
  input wire [10:0] i_hw_trig, // PWM and timer trigger pulses
  input wire i_timer2_trig, // Timer2 period match pulse
  input wire i_conv_done, // Converter finished the granted pair
  output reg o_conv_on, // Converter powered on
  output reg o_conv_clock_select, // 1 auxiliary PLL, 0 primary PLL
  output reg o_conv_start, // One-cycle start pulse to converter
  output reg [1:0] o_conv_pair, // Pair index being converted
  output reg o_conv_internal_ref, // Reference pair: set on every conversion of the last pair, clear on the others
  output reg [NPAIR-1:0] o_pair_irq // Conversion complete requests
);
  localparam ST_IDLE = 2'b01;
  localparam ST_CONV = 2'b10;
  reg [15:0] global_reg;
  reg [7:0] pair_reg [0:NPAIR-1];
  reg [1:0] state_reg;
  reg [1:0] cur_reg;
  reg [3:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg aw_have_reg;
  reg w_have_reg;
  reg [1:0] rr_reg;
  wire [NPAIR-1:0] pend;
  wire [NPAIR-1:0] busy;
  wire [NPAIR-1:0] soft_clr;
  wire [NPAIR-1:0] grant;
  wire [NPAIR-1:0] done;
  wire run;
  wire do_write;
  reg [1:0] pick;
  reg pick_ok;
  reg [31:0] rd_val;
  reg rd_ok;
  integer k;
  integer idx;
  wire [15:0] locked_wr;
  wire [15:0] open_wr;
  // Frozen fields keep their value while on; only the run-time bits take the write
  assign locked_wr = (global_reg & `APTC_LOCKED_MASK)
    | (wdata_reg[15:0] & (`APTC_GLOBAL_WMASK & ~`APTC_LOCKED_MASK));
  assign open_wr = wdata_reg[15:0] & `APTC_GLOBAL_WMASK;
  // Converter runs only when on and not stopped by idle
  assign run = global_reg[`APTC_BIT_CONV_ON] & ~(global_reg[`APTC_BIT_IDLE_STOP] & i_idle);
  assign do_write = aw_have_reg & w_have_reg & ~o_bvalid;
  // One trigger path per pair, all independent
  genvar g;
  generate
    for (g = 0; g < NPAIR; g = g + 1) begin : gen_pair
      wire [10:0] trig_in;
      // Timer2 code aliases to the timer1 lane only if routed; swap in timer2 for that code
      assign trig_in = (pair_reg[g][4:0] == `APTC_TS_TMR2) ? {i_timer2_trig, i_hw_trig[9:0]} : i_hw_trig;
      assign grant[g] = o_conv_start & (o_conv_pair == g);
      assign done[g] = i_conv_done & (state_reg == ST_CONV) & (cur_reg == g);
      aptc_pair_slot u_slot (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_run(run),
        .i_sel(pair_reg[g][4:0]),
        .i_soft_trig(pair_reg[g][`APTC_BIT_SOFT_TRIG]),
        .i_global_trig(global_reg[`APTC_BIT_GLOBAL_TRIG]),
        .i_hw_trig(trig_in),
        .i_grant(grant[g]),
        .i_done(done[g]),
        .o_pending(pend[g]),
        .o_busy(busy[g]),
        .o_soft_clear(soft_clr[g])
      );
    end
  endgenerate
  // Round robin over waiting pairs so none starves while the converter is shared
  always @* begin
    pick = 2'h0;
    pick_ok = 1'b0;
    idx = 0;
    for (k = NPAIR - 1; k >= 0; k = k - 1) begin
      idx = (k + rr_reg) % NPAIR;
      if (pend[idx] && !busy[idx]) begin
        pick = idx[1:0];
        pick_ok = 1'b1;
      end
    end
  end
  // Sequencer: one conversion at a time, waiting pairs stay pending
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= ST_IDLE;
      cur_reg <= 2'h0;
      rr_reg <= 2'h0;
      o_conv_start <= 1'b0;
      o_conv_pair <= 2'h0;
      o_conv_internal_ref <= 1'b0;
      o_pair_irq <= {NPAIR{1'b0}};
    end else begin
      o_conv_start <= 1'b0;
      for (k = 0; k < NPAIR; k = k + 1) begin
        o_pair_irq[k] <= done[k] & pair_reg[k][`APTC_BIT_IRQ_ENABLE];
      end
      case (state_reg)
        ST_IDLE: begin
          if (run && pick_ok && !o_conv_start) begin
            o_conv_start <= 1'b1;
            o_conv_pair <= pick;
            o_conv_internal_ref <= (pick == NPAIR - 1);
            cur_reg <= pick;
            rr_reg <= (pick == NPAIR - 1) ? 2'h0 : pick + 2'h1;
            state_reg <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (i_conv_done || !global_reg[`APTC_BIT_CONV_ON]) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
  // Write channel: address and data taken in either order, response after both
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 4'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= `APTC_AXI_OKAY;
    end else begin
      o_awready <= ~aw_have_reg & ~o_awready & i_awvalid;
      o_wready <= ~w_have_reg & ~o_wready & i_wvalid;
      if (o_awready && i_awvalid) begin
        aw_have_reg <= 1'b1;
        awaddr_reg <= i_awaddr;
      end
      if (o_wready && i_wvalid) begin
        w_have_reg <= 1'b1;
        wdata_reg <= i_wdata;
        wstrb_reg <= i_wstrb;
      end
      if (do_write) begin
        o_bvalid <= 1'b1;
        o_bresp <= (awaddr_reg == `APTC_OFF_PAIR_STATUS || awaddr_reg[1:0] != 2'h0) ? `APTC_AXI_SLVERR : `APTC_AXI_OKAY;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end
  // Register file; hardware sets of pending and clears of soft trigger win over software
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      global_reg <= `APTC_GLOBAL_RESET;
      for (k = 0; k < NPAIR; k = k + 1) begin
        pair_reg[k] <= `APTC_PAIR_RESET;
      end
      o_conv_on <= 1'b0;
      o_conv_clock_select <= 1'b0;
    end else begin
      if (do_write && awaddr_reg == `APTC_OFF_GLOBAL_CONTROL) begin
        // Configuration fields freeze while the converter is on
        if (global_reg[`APTC_BIT_CONV_ON]) begin
          if (wstrb_reg[1]) begin
            global_reg[15:8] <= locked_wr[15:8];
          end
        end else begin
          if (wstrb_reg[0]) begin
            global_reg[7:0] <= open_wr[7:0];
          end
          if (wstrb_reg[1]) begin
            global_reg[15:8] <= open_wr[15:8];
          end
        end
      end
      for (k = 0; k < NPAIR; k = k + 1) begin
        if (do_write && ((k < 2 && awaddr_reg == `APTC_OFF_PAIR_CONTROL_0 && wstrb_reg[k])
            || (k == 2 && awaddr_reg == `APTC_OFF_PAIR_CONTROL_3 && wstrb_reg[0]))) begin
          pair_reg[k] <= (k < 2) ? wdata_reg[8*(k%2)+:8] : wdata_reg[7:0];
        end
        if (soft_clr[k]) begin
          pair_reg[k][`APTC_BIT_SOFT_TRIG] <= 1'b0;
        end
      end
      o_conv_on <= global_reg[`APTC_BIT_CONV_ON] & ~(global_reg[`APTC_BIT_IDLE_STOP] & i_idle);
      o_conv_clock_select <= global_reg[`APTC_BIT_CLOCK_SELECT];
    end
  end
  // Read decode; pending shows live hardware state
  always @* begin
    rd_val = 32'h0;
    rd_ok = 1'b1;
    case (i_araddr)
      `APTC_OFF_GLOBAL_CONTROL: rd_val = {16'h0, global_reg};
      `APTC_OFF_PAIR_CONTROL_0: rd_val = {16'h0, pair_reg[1][7], pend[1], pair_reg[1][5:0],
        pair_reg[0][7], pend[0], pair_reg[0][5:0]};
      `APTC_OFF_PAIR_CONTROL_3: rd_val = {24'h0, pair_reg[2][7], pend[2], pair_reg[2][5:0]};
      `APTC_OFF_PAIR_STATUS: rd_val = {26'h0, state_reg == ST_CONV, busy[2] | busy[1] | busy[0], 1'b0, pend};
      default: rd_ok = 1'b0;
    endcase
  end
  // Read channel: address taken, data one cycle later
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0;
      o_rresp <= `APTC_AXI_OKAY;
    end else begin
      o_arready <= ~o_arready & ~o_rvalid & i_arvalid;
      if (o_arready && i_arvalid) begin
        o_rvalid <= 1'b1;
        o_rdata <= rd_val;
        o_rresp <= rd_ok ? `APTC_AXI_OKAY : `APTC_AXI_SLVERR;
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end
endmodule

// >>> verification/aptc_top_assertions.sv
// Port-level checks of the pair trigger controller
`timescale 1ns/1ns
module aptc_top_chk #(
  parameter NPAIR = 3 // Pair count from the block
) (
  input wire i_clk, // Clock
  input wire i_resetn, // Reset, active low
  input wire i_conv_done, // Converter done
  input wire o_awready, // Write address ready
  input wire o_conv_on, // Converter on
  input wire o_conv_start, // Start pulse
  input wire [1:0] o_conv_pair, // Pair index
  input wire o_conv_internal_ref, // Reference pair flag
  input wire [NPAIR-1:0] o_pair_irq // Completion requests
);
  reg busy_reg;
  // Converter occupancy; an abort frees it too, so no false overlap
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_reg <= 1'b0;
    end else if (o_conv_start) begin
      busy_reg <= 1'b1;
    end else if (i_conv_done || !o_conv_on) begin
      busy_reg <= 1'b0;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  property p_start_on; o_conv_start |-> o_conv_on; endproperty
  a_start_on: assert property (p_start_on) else $error("start while off");
  property p_start_pulse; o_conv_start |=> !o_conv_start; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  property p_one_busy; o_conv_start |-> !busy_reg; endproperty
  a_one_busy: assert property (p_one_busy) else $error("start while busy");
  property p_irq_cause; |o_pair_irq |-> $past(i_conv_done); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without done");
  property p_irq_onehot; $onehot0(o_pair_irq); endproperty
  a_irq_onehot: assert property (p_irq_onehot) else $error("irq on two pairs");
  property p_irq_pulse; |o_pair_irq |=> o_pair_irq == '0; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
  property p_ref_pair; o_conv_start |=> o_conv_internal_ref == (o_conv_pair == 2'h2); endproperty
  a_ref_pair: assert property (p_ref_pair) else $error("reference flag wrong");
  property p_pair_range; o_conv_start |-> o_conv_pair != 2'h3; endproperty
  a_pair_range: assert property (p_pair_range) else $error("bad pair index");
  property p_aw_pulse; o_awready |=> !o_awready; endproperty
  a_aw_pulse: assert property (p_aw_pulse) else $error("awready too long");
endmodule
bind aptc_top aptc_top_chk #(.NPAIR(NPAIR)) u_chk (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_conv_done(i_conv_done), .o_awready(o_awready), .o_conv_on(o_conv_on), .o_conv_start(o_conv_start),
  .o_conv_pair(o_conv_pair), .o_conv_internal_ref(o_conv_internal_ref), .o_pair_irq(o_pair_irq));

// >>> verification/aptc_conv_model.sv
// Converter core model: finishes each started pair after a set latency
`timescale 1ns/1ns
module aptc_conv_model (
  input wire i_clk, // Clock
  input wire i_resetn, // Reset, active low
  input wire i_start, // Start pulse
  input wire [3:0] i_lat, // Cycles to done, 1 is prompt
  output reg o_done // Done pulse
);
  reg [3:0] left_reg;
  // One conversion at a time; slow latency keeps later requests waiting
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      left_reg <= 4'h0;
      o_done <= 1'b0;
    end else begin
      o_done <= (left_reg == 4'h1);
      if (i_start) begin
        left_reg <= i_lat;
      end else if (left_reg != 4'h0) begin
        left_reg <= left_reg - 4'h1;
      end
    end
  end
endmodule

// >>> verification/testbench.sv
// Register-level bench of the pair trigger controller
`timescale 1ns/1ns
module testbench;
  reg clk = 0, rstn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, idle = 0, t2 = 0;
  reg [3:0] aw = 4'h0, ar = 4'h0, ws = 4'h0, lat = 4'h1;
  reg [31:0] wd = 32'h0;
  reg [10:0] hw = 11'h000;
  wire awr, wrd, bv, arr, rv, on, cks, st, iref, done;
  wire [1:0] bresp, rresp, pair;
  wire [31:0] rdata;
  wire [2:0] irq;
  integer failures = 0, tests_run = 0, n, i;
  integer cnt [0:6] = '{0, 0, 0, 0, 0, 0, 0};
  integer exp_t [0:5] = '{2, 12, 1, 1, 0, 0};
  reg [4:0] codes [0:10] = '{5'h03, 5'h04, 5'h05, 5'h07, 5'h0E, 5'h0F, 5'h11, 5'h17, 5'h18, 5'h1A, 5'h0C};
  aptc_top u_dut (.i_clk(clk), .i_resetn(rstn), .i_awaddr(aw), .i_awvalid(awv), .o_awready(awr),
    .i_wdata(wd), .i_wstrb(ws), .i_wvalid(wv), .o_wready(wrd), .o_bresp(bresp), .o_bvalid(bv),
    .i_bready(br), .i_araddr(ar), .i_arvalid(arv), .o_arready(arr), .o_rdata(rdata), .o_rresp(rresp),
    .o_rvalid(rv), .i_rready(rr), .i_idle(idle), .i_hw_trig(hw), .i_timer2_trig(t2), .i_conv_done(done),
    .o_conv_on(on), .o_conv_clock_select(cks), .o_conv_start(st), .o_conv_pair(pair),
    .o_conv_internal_ref(iref), .o_pair_irq(irq));
  aptc_conv_model u_core (.i_clk(clk), .i_resetn(rstn), .i_start(st), .i_lat(lat), .o_done(done));
  initial forever #5 clk = ~clk;
  // Tally starts and requests per pair, and completions over all pairs
  always @(posedge clk) begin
    if (st) cnt[pair] <= cnt[pair] + 1;
    if (irq[0]) cnt[3] <= cnt[3] + 1;
    if (irq[1]) cnt[4] <= cnt[4] + 1;
    if (irq[2]) cnt[5] <= cnt[5] + 1;
    if (done) cnt[6] <= cnt[6] + 1;
  end
  task chk(input string nm, input [31:0] s, input [31:0] e);
    begin
      tests_run = tests_run + 1;
      if (s !== e) begin
        failures = failures + 1;
        $display("Error %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  // Address and data offered together, each dropped once taken
  task wr(input [3:0] a, input [3:0] s, input [31:0] d, input [1:0] er);
    begin
      aw <= a;
      ws <= s;
      wd <= d;
      awv <= 1;
      wv <= 1;
      br <= 1;
      n = 0;
      do begin
        @(posedge clk);
        n = n + 1;
        if (awr) awv <= 0;
        if (wrd) wv <= 0;
      end while (!bv && n < 50);
      br <= 0;
      chk("bvalid", bv, 1);
      chk("bresp", bresp, er);
    end
  endtask
  task rd(input [3:0] a, input [31:0] e, input [1:0] er);
    begin
      ar <= a;
      arv <= 1;
      rr <= 1;
      n = 0;
      do begin
        @(posedge clk);
        n = n + 1;
        if (arr) arv <= 0;
      end while (!rv && n < 50);
      rr <= 0;
      chk("rvalid", rv, 1);
      chk("rresp", rresp, er);
      if (er == 2'h0) chk("rdata", rdata, e);
    end
  endtask
  // Bounded wait for a tally to reach its target
  task waitc(input integer k, input integer t);
    begin
      n = 0;
      while (cnt[k] < t && n < 100) begin
        @(posedge clk);
        n = n + 1;
      end
      chk("tally", cnt[k], t);
    end
  endtask
  task pulse(input [10:0] h, input x);
    begin
      hw <= h;
      t2 <= x;
      @(posedge clk);
      hw <= 11'h000;
      t2 <= 0;
    end
  endtask
  task conclude;
    begin
      $display("Checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    #300000;
    failures = failures + 1;
    conclude;
  end
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    rd(4'h0, 32'h0003, 2'h0);
    rd(4'h8, 32'h0000, 2'h0);
    rd(4'h2, 32'h0, 2'h2);
    wr(4'hC, 4'hF, 32'h0, 2'h2);
    wr(4'h0, 4'hF, 32'h1003, 2'h0);
    // Clock select is registered once more after the write lands
    @(posedge clk);
    chk("clock_select", cks, 1);
    wr(4'h0, 4'hF, 32'h9003, 2'h0);
    wr(4'h0, 4'hF, 32'h8000, 2'h0);
    rd(4'h0, 32'h9003, 2'h0);
    chk("conv_on", on, 1);
    wr(4'h4, 4'h1, 32'h00A1, 2'h0);
    waitc(0, 1);
    waitc(3, 1);
    rd(4'h4, 32'h0081, 2'h0);
    lat <= 4'h8;
    for (i = 0; i < 11; i = i + 1) begin
      wr(4'h4, 4'h2, {19'h0, codes[i], 8'h00}, 2'h0);
      pulse(~(11'h001 << i), 1);
      rd(4'h4, {19'h0, codes[i], 8'h81}, 2'h0);
      pulse(11'h001 << i, 0);
      waitc(1, i + 1);
      waitc(6, i + 2);
    end
    wr(4'h4, 4'h2, 32'h0600, 2'h0);
    pulse(11'h7FF, 1);
    rd(4'h4, 32'h0681, 2'h0);
    wr(4'h4, 4'h2, 32'h1F00, 2'h0);
    pulse(11'h000, 1);
    waitc(1, 12);
    waitc(6, 13);
    lat <= 4'h9;
    wr(4'h4, 4'h1, 32'h0002, 2'h0);
    wr(4'h8, 4'h1, 32'h0002, 2'h0);
    wr(4'h0, 4'h3, 32'h9403, 2'h0);
    waitc(2, 1);
    chk("internal_ref", iref, 1);
    waitc(0, 2);
    waitc(6, 15);
    wr(4'h0, 4'h3, 32'hB003, 2'h0);
    idle <= 1;
    repeat (3) @(posedge clk);
    chk("conv_on", on, 0);
    idle <= 0;
    repeat (3) @(posedge clk);
    chk("conv_on", on, 1);
    for (i = 0; i < 6; i = i + 1) chk("tally", cnt[i], exp_t[i]);
    conclude;
  end
endmodule
